// File: rtl/tx_template_map.vh
// Register map, field positions and reset values of the transmit template registers.
`ifndef TX_TEMPLATE_MAP_VH
`define TX_TEMPLATE_MAP_VH
`define ADDR_DRV_TPL_CFG   8'h05
`define ADDR_AMP_SCALE     8'h06
`define ADDR_RAM_CTRL      8'h07
`define ADDR_RAM_DATA      8'h08
`define RST_DRV_TPL_CFG    8'h10
`define RST_AMP_SCALE      8'h21
`define RST_RAM_CTRL       8'h00
`define RST_RAM_DATA       7'h00
`define BIT_DRIVER_FAIL_MONITOR_OFF        5
`define BIT_HIZ            4
`define BIT_GO             7
`define BIT_DIR            6
`define TPL_SEL_75         4'h0
`define TPL_SEL_120        4'h1
`define TPL_USER_MSB       2'h3
`define TPL_KIND_75        2'h0
`define TPL_KIND_120       2'h1
`define TPL_KIND_USER      2'h2
`define TPL_KIND_RSVD      2'h3
`define PULS_RANGE         3:0
`define USER_RANGE         3:2
`define SCALE_RANGE        5:0
`define IDX_RANGE          5:0
`define AMP_RANGE          6:0
`define RST_SCALE_FIELD    6'h21
`define RST_RDATA          8'h00
`endif

// File: rtl/template_ram.v
// Flip-flop storage for the per-channel user pulse template samples.
`timescale 1ns/1ns
`default_nettype none
module template_ram #(
  parameter AW = 6,
  parameter DW = 7
) (
  input  wire          clock_i,
  input  wire          we_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge clock_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule
`default_nettype wire

// File: rtl/tx_pulse_template_config.v
// Transmit driver, pulse template and template RAM access registers.
`timescale 1ns/1ns
`default_nettype none
`include "tx_template_map.vh"
module tx_pulse_template_config #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clock_i,
  input  wire          rst_i,
  input  wire          wr_i,
  input  wire          rd_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o,
  output reg           driver_fail_monitor_o,
  output reg           line_driver_hiz_o,
  output reg  [1:0]    template_kind_o,
  output reg  [5:0]    amplitude_scale_o,
  output reg           ram_busy_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam RAM_AW  = 6;
  localparam RAM_DW  = 7;

  reg  [7:0]        cfg_q;
  reg  [7:0]        cfg_d;
  reg  [7:0]        scale_q;
  reg  [7:0]        scale_d;
  reg  [7:0]        ctrl_q;
  reg  [7:0]        ctrl_d;
  reg  [RAM_DW-1:0] template_amplitude_q;
  reg  [RAM_DW-1:0] template_amplitude_d;
  reg  [1:0]        state_q;
  reg  [1:0]        state_d;
  reg               dir_q;
  reg               dir_d;
  reg  [DW-1:0]     rdata_d;
  reg               ram_we;
  wire [RAM_DW-1:0] ram_rdata;
  wire              idle;
  wire              wr_cfg;
  wire              wr_scale;
  wire              wr_ctrl;
  wire              wr_data;
  wire              go;

  // Tells whether a strobe addresses one register.
  function hit;
    input          strobe;
    input [AW-1:0] addr;
    input [AW-1:0] target;
    begin
      hit = strobe && (addr == target);
    end
  endfunction

  // Maps the template select code onto the kind of template in use.
  function [1:0] kind_of;
    input [3:0] sel;
    begin
      if (sel == `TPL_SEL_75) begin
        kind_of = `TPL_KIND_75;
      end else if (sel == `TPL_SEL_120) begin
        kind_of = `TPL_KIND_120;
      end else if (sel[`USER_RANGE] == `TPL_USER_MSB) begin
        kind_of = `TPL_KIND_USER;
      end else begin
        kind_of = `TPL_KIND_RSVD;
      end
    end
  endfunction

  // Control and data writes are refused while an access runs.
  assign idle     = (state_q == ST_IDLE);
  assign wr_cfg   = hit(wr_i, addr_i, `ADDR_DRV_TPL_CFG);
  assign wr_scale = hit(wr_i, addr_i, `ADDR_AMP_SCALE);
  assign wr_ctrl  = hit(wr_i, addr_i, `ADDR_RAM_CTRL) && idle;
  assign wr_data  = hit(wr_i, addr_i, `ADDR_RAM_DATA) && idle;
  assign go       = wr_ctrl && wdata_i[`BIT_GO];

  // Next values of the registers and of the access engine.
  always @* begin
    cfg_d                = cfg_q;
    scale_d              = scale_q;
    ctrl_d               = ctrl_q;
    template_amplitude_d = template_amplitude_q;
    state_d              = state_q;
    dir_d                = dir_q;
    if (wr_cfg) begin
      cfg_d = wdata_i;
    end
    if (wr_scale) begin
      scale_d = {2'b00, wdata_i[`SCALE_RANGE]};
    end
    if (wr_ctrl) begin
      ctrl_d = wdata_i;
    end
    if (wr_data) begin
      template_amplitude_d = wdata_i[`AMP_RANGE];
    end
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          dir_d   = wdata_i[`BIT_DIR];
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        if (dir_q) begin
          template_amplitude_d = ram_rdata;
        end
        ctrl_d[`BIT_GO] = 1'b0;
        state_d         = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read data holds between read strobes.
  always @* begin
    rdata_d = rdata_o;
    if (rd_i) begin
      case (addr_i)
        `ADDR_DRV_TPL_CFG: rdata_d = cfg_q;
        `ADDR_AMP_SCALE:   rdata_d = scale_q;
        `ADDR_RAM_CTRL:    rdata_d = ctrl_q;
        `ADDR_RAM_DATA:    rdata_d = {1'b0, template_amplitude_q};
        default:           rdata_d = `RST_RDATA;
      endcase
    end
  end

  always @* begin
    ram_we = (state_q == ST_RUN) && !dir_q;
  end

  // The sample index is the interval and sample fields together.
  template_ram #(
    .AW (RAM_AW),
    .DW (RAM_DW)
  ) template_ram_i (
    .clock_i (clock_i),
    .we_i    (ram_we),
    .addr_i  (ctrl_q[`IDX_RANGE]),
    .wdata_i (template_amplitude_q),
    .rdata_o (ram_rdata)
  );

  // Configuration registers and read data.
  always @(posedge clock_i) begin
    if (rst_i) begin
      cfg_q   <= `RST_DRV_TPL_CFG;
      scale_q <= `RST_AMP_SCALE;
      rdata_o <= `RST_RDATA;
    end else begin
      cfg_q   <= cfg_d;
      scale_q <= scale_d;
      rdata_o <= rdata_d;
    end
  end

  // Access engine and its registers.
  always @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_q               <= `RST_RAM_CTRL;
      template_amplitude_q <= `RST_RAM_DATA;
      state_q              <= ST_IDLE;
      dir_q                <= 1'b0;
    end else begin
      ctrl_q               <= ctrl_d;
      template_amplitude_q <= template_amplitude_d;
      state_q              <= state_d;
      dir_q                <= dir_d;
    end
  end

  // Status outputs lag their registers by one clock, except that ram_busy_o rises at the same edge as the go write.
  always @(posedge clock_i) begin
    if (rst_i) begin
      driver_fail_monitor_o <= 1'b1;
      line_driver_hiz_o     <= 1'b1;
      template_kind_o       <= `TPL_KIND_75;
      amplitude_scale_o     <= `RST_SCALE_FIELD;
      ram_busy_o            <= 1'b0;
    end else begin
      driver_fail_monitor_o <= !cfg_q[`BIT_DRIVER_FAIL_MONITOR_OFF];
      line_driver_hiz_o     <= cfg_q[`BIT_HIZ];
      template_kind_o       <= kind_of(cfg_q[`PULS_RANGE]);
      amplitude_scale_o     <= scale_q[`SCALE_RANGE];
      ram_busy_o            <= !idle || go;
    end
  end
endmodule
`default_nettype wire

// File: sim/tx_template_properties.sv
// Concurrent checks on the transmit template register block ports.
`timescale 1ns/1ns
`default_nettype none
module tx_template_properties (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       driver_fail_monitor_o,
  input wire logic       line_driver_hiz_o,
  input wire logic [1:0] template_kind_o,
  input wire logic [5:0] amplitude_scale_o,
  input wire logic       ram_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire c5 = wr_i && addr_i == 8'h05;
  monitor_off_a: assert property (c5 |-> ##2
    driver_fail_monitor_o == !$past(wdata_i[5], 2)) else $error("monitor");
  hiz_follow_a: assert property (c5 |-> ##2
    line_driver_hiz_o == $past(wdata_i[4], 2)) else $error("hiz");
  user_kind_a: assert property (c5 && wdata_i[3:2] == 2'h3
    |-> ##2 template_kind_o == 2'h2) else $error("user kind");
  rsvd_kind_a: assert property (c5 && wdata_i[3:0] inside {[2:11]}
    |-> ##2 template_kind_o == 2'h3) else $error("reserved kind");
  scale_follow_a: assert property (wr_i && addr_i == 8'h06 |-> ##2
    amplitude_scale_o == $past(wdata_i[5:0], 2)) else $error("scale");
  launch_busy_a: assert property (wr_i && addr_i == 8'h07
    && wdata_i[7] && !ram_busy_o |-> ##1 ram_busy_o [*3] ##1 !ram_busy_o)
    else $error("busy");
  rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("rdata moved");
  unmapped_zero_a: assert property (rd_i && !(addr_i inside {[5:8]})
    |=> rdata_o == 8'h00) else $error("unmapped");
  reset_value_a: assert property (disable iff (1'b0)
    rst_i ##1 rst_i |=> line_driver_hiz_o && driver_fail_monitor_o
    && amplitude_scale_o == 6'h21 && !ram_busy_o) else $error("reset");
  cover property (c5 && wdata_i[3:2] == 2'h3);
  cover property (wr_i && addr_i == 8'h07 && wdata_i[7:6] == 2'h3);
  cover property (rd_i && addr_i == 8'h08);
endmodule
`default_nettype wire

// File: sim/test_tx_pulse_template_config.sv
// Register sequence bench for the transmit template register block.
`timescale 1ns/1ns
`default_nettype none
module test_tx_pulse_template_config;
  logic       clock_i, rst_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i;
  wire  [7:0] rdata_o;
  wire        driver_fail_monitor_o, line_driver_hiz_o, ram_busy_o;
  wire  [1:0] template_kind_o;
  wire  [5:0] amplitude_scale_o;
  int         n_errors = 0, num_checks = 0, i, j;
  logic [5:0] ix [3] = '{6'h00, 6'h3F, 6'h25};
  tx_pulse_template_config tx_pulse_template_config_i (.clock_i, .rst_i,
    .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .driver_fail_monitor_o,
    .line_driver_hiz_o, .template_kind_o, .amplitude_scale_o, .ram_busy_o);
  task close_out;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) #1 {wr_i, addr_i, wdata_i} = {1'b1, a, d};
    @(posedge clock_i) #1 wr_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i) #1 {rd_i, addr_i} = {1'b1, a};
    @(posedge clock_i) #1 rd_i = 0;
    chk(rdata_o, e);
  endtask
  task idle;
    for (int k = 0; k < 10 && ram_busy_o !== 1'b0; k++) @(posedge clock_i) #1;
    if (ram_busy_o !== 1'b0) begin
      n_errors++;
      close_out;
    end
  endtask
  function automatic logic [1:0] kind_of(input int c);
    return c < 2 ? c[1:0] : (c > 11 ? 2'h2 : 2'h3);
  endfunction
  initial begin
    clock_i = 0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'h4, 16'h0000};
    repeat (12) @(posedge clock_i);
    #1 rst_i = 0;
    chk({4'h0, driver_fail_monitor_o, line_driver_hiz_o, template_kind_o},
      8'h0C);
    chk({2'h0, amplitude_scale_o}, 8'h21);
    rd(8'h05, 8'h10);
    rd(8'h06, 8'h21);
    rd(8'h07, 8'h00);
    rd(8'h09, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr(8'h05, 8'h20 | i[7:0]);
      @(posedge clock_i) #1;
      chk({4'h0, driver_fail_monitor_o, line_driver_hiz_o, template_kind_o},
        {6'h00, kind_of(i)});
    end
    wr(8'h05, 8'h01);
    @(posedge clock_i) #1;
    chk({4'h0, driver_fail_monitor_o, line_driver_hiz_o, template_kind_o},
      8'h09);
    rd(8'h05, 8'h01);
    wr(8'h06, 8'hFF);
    @(posedge clock_i) #1;
    chk({2'h0, amplitude_scale_o}, 8'h3F);
    rd(8'h06, 8'h3F);
    for (j = 0; j < 3; j++) begin
      wr(8'h08, {2'h1, ix[j]});
      wr(8'h07, {2'h2, ix[j]});
      chk({7'h00, ram_busy_o}, 8'h01);
      wr(8'h08, 8'h00);
      idle;
      rd(8'h07, {2'h0, ix[j]});
      rd(8'h08, {2'h1, ix[j]});
    end
    for (j = 0; j < 3; j++) begin
      wr(8'h07, {2'h3, ix[j]});
      idle;
      rd(8'h08, {2'h1, ix[j]});
      rd(8'h07, {2'h1, ix[j]});
    end
    close_out;
  end
endmodule
bind tx_pulse_template_config tx_template_properties tx_template_properties_i
  (.clock_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
  .driver_fail_monitor_o, .line_driver_hiz_o, .template_kind_o,
  .amplitude_scale_o, .ram_busy_o);
`default_nettype wire
